/* design/shrp_dev.sv */
`timescale 1ns/10ps
`default_nettype none
module shrp_dev
  import shrp_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // serial link
  shrp_if.dev link,
  // local register update
  input wire logic loc_we_i,
  input wire logic [ADDR_BITS-1:0] loc_addr_i,
  input wire logic [DATA_BITS-1:0] loc_data_i,
  // access events
  output logic wr_stb_o,
  output logic rd_stb_o,
  output logic abort_o,
  output logic busy_o,
  output logic [ADDR_BITS-1:0] reg_addr_o,
  output logic [DATA_BITS-1:0] reg_data_o
);

  // ==========================================================
  // pin synchronisers
  logic cs_s1, cs_s2, cs_s3;
  logic ck_s1, ck_s2, ck_s3;
  logic di_s1, di_s2;

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      ck_s1 <= 1'b0;
      ck_s2 <= 1'b0;
      ck_s3 <= 1'b0;
      di_s1 <= 1'b0;
      di_s2 <= 1'b0;
    end else begin
      cs_s1 <= link.cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      ck_s1 <= link.sclk;
      ck_s2 <= ck_s1;
      ck_s3 <= ck_s2;
      di_s1 <= link.serial_in_line;
      di_s2 <= di_s1;
    end
  end

  logic cs_fall, cs_rise, ck_rise, ck_fall;

  always_comb begin
    cs_fall = cs_s3 & ~cs_s2; // see R1
    cs_rise = ~cs_s3 & cs_s2; // see R1
    ck_rise = ~ck_s3 & ck_s2;
    ck_fall = ck_s3 & ~ck_s2;
  end

  // ==========================================================
  // register array
  logic [DATA_BITS-1:0] mem [0:(1<<ADDR_BITS)-1];

  // ==========================================================
  // frame state
  shrp_dev_st_t state, next_state;
  logic [3:0] cnt, next_cnt;
  logic [INSTR_BITS-1:0] instr, next_instr;
  logic [ADDR_BITS-1:0] addr, next_addr;
  logic [DATA_BITS-1:0] shreg, next_shreg;
  logic out_bit, next_out_bit;
  logic oe, next_oe;
  logic wr_stb, next_wr_stb;
  logic rd_stb, next_rd_stb;
  logic abort, next_abort;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_instr = instr;
    next_addr = addr;
    next_shreg = shreg;
    next_out_bit = out_bit;
    next_oe = oe;
    next_wr_stb = 1'b0;
    next_rd_stb = 1'b0;
    next_abort = 1'b0;
    case (state)
      DEV_IDLE: begin
        next_oe = 1'b0;
        if (cs_fall) begin // see R1
          next_state = DEV_INSTR;
          next_cnt = CNT_ZERO;
        end
      end
      DEV_INSTR: begin
        if (ck_rise) begin
          next_instr = {instr[INSTR_BITS-2:0], di_s2}; // see R2
          if (cnt == INSTR_LAST) begin
            next_state = DEV_ADDR;
            next_cnt = CNT_ZERO;
          end else begin
            next_cnt = cnt + CNT_ONE;
          end
        end
      end
      DEV_ADDR: begin
        if (ck_rise) begin
          next_addr = {addr[ADDR_BITS-2:0], di_s2}; // see R4
          if (cnt == ADDR_LAST) begin
            next_cnt = CNT_ZERO;
            if (instr[INSTR_BITS-1] == RD_OP) begin // see R3
              next_state = DEV_RDATA;
              next_shreg = mem[next_addr]; // see R5
              next_rd_stb = 1'b1;
            end else begin
              next_state = DEV_WDATA;
            end
          end else begin
            next_cnt = cnt + CNT_ONE;
          end
        end
      end
      DEV_RDATA: begin
        if (ck_fall) begin
          next_out_bit = shreg[DATA_BITS-1]; // see R5
          next_shreg = {shreg[DATA_BITS-2:0], 1'b0}; // see R7
          next_oe = 1'b1;
          if (cnt == DATA_LAST) begin
            next_state = DEV_DONE;
          end else begin
            next_cnt = cnt + CNT_ONE;
          end
        end
      end
      DEV_WDATA: begin
        if (ck_rise) begin
          next_shreg = {shreg[DATA_BITS-2:0], di_s2}; // see R6
          if (cnt == DATA_LAST) begin
            next_state = DEV_DONE;
            next_wr_stb = 1'b1; // see R6
          end else begin
            next_cnt = cnt + CNT_ONE;
          end
        end
      end
      DEV_DONE: begin
        next_cnt = CNT_ZERO;
      end
      default: begin
        next_state = DEV_IDLE;
      end
    endcase
    // select high ends the frame from any state
    if (cs_s2 && state != DEV_IDLE) begin // see R1
      next_state = DEV_IDLE;
      next_oe = 1'b0; // see R7
      next_abort = cs_rise && state != DEV_DONE;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      state <= DEV_IDLE;
      cnt <= CNT_ZERO;
      instr <= '0;
      addr <= ADDR_ZERO;
      shreg <= DATA_ZERO;
      out_bit <= 1'b0;
      oe <= 1'b0;
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      abort <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      instr <= next_instr;
      addr <= next_addr;
      shreg <= next_shreg;
      out_bit <= next_out_bit;
      oe <= next_oe;
      wr_stb <= next_wr_stb;
      rd_stb <= next_rd_stb;
      abort <= next_abort;
    end
  end

  // ==========================================================
  // register writes, serial write wins over local update
  always_ff @(posedge sys_clk_i) begin
    if (wr_stb) begin
      mem[addr] <= shreg; // see R6
    end else if (loc_we_i) begin
      mem[loc_addr_i] <= loc_data_i;
    end
  end

  // ==========================================================
  // outputs
  always_comb begin
    link.out_data = out_bit;
    link.out_oe = oe; // see R7
    wr_stb_o = wr_stb;
    rd_stb_o = rd_stb;
    abort_o = abort;
    busy_o = (state != DEV_IDLE);
    reg_addr_o = addr;
    reg_data_o = shreg;
  end

endmodule
`default_nettype wire

/* design/shrp_host.sv */
`timescale 1ns/10ps
`default_nettype none
module shrp_host
  import shrp_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // serial link
  shrp_if.host link,
  // request
  input wire logic req_i,
  input wire logic req_rd_i,
  input wire logic [ADDR_BITS-1:0] req_addr_i,
  input wire logic [DATA_BITS-1:0] req_wdata_i,
  output logic req_ready_o,
  // answer
  output logic done_o,
  output logic [DATA_BITS-1:0] rdata_o
);

  // ==========================================================
  // read-back synchroniser
  logic do_s1, do_s2;

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      do_s1 <= 1'b1;
      do_s2 <= 1'b1;
    end else begin
      do_s1 <= link.serial_out_line;
      do_s2 <= do_s1;
    end
  end

  // ==========================================================
  // frame sequencer
  shrp_hst_st_t state, next_state;
  logic [7:0] tmr, next_tmr;
  logic [4:0] bitn, next_bitn;
  logic [FRAME_BITS-1:0] frame, next_frame;
  logic [DATA_BITS-1:0] rx, next_rx;
  logic [DATA_BITS-1:0] rdata, next_rdata;
  logic rd, next_rd;
  logic cs_n, next_cs_n;
  logic sclk, next_sclk;
  logic tx_bit, next_tx_bit;
  logic done, next_done;

  always_comb begin
    next_state = state;
    next_tmr = tmr;
    next_bitn = bitn;
    next_frame = frame;
    next_rx = rx;
    next_rdata = rdata;
    next_rd = rd;
    next_cs_n = cs_n;
    next_sclk = sclk;
    next_tx_bit = tx_bit;
    next_done = 1'b0;
    case (state)
      HST_IDLE: begin
        if (req_i) begin
          // msb first: instruction, address, data
          next_frame = {(req_rd_i ? RD_OP : WR_OP), INSTR_PAD, req_addr_i,
                        req_wdata_i}; // see R3
          next_rd = req_rd_i;
          next_cs_n = 1'b0; // see R1
          next_bitn = '0;
          next_tmr = CS_SETUP_CYC - TMR_ONE;
          next_state = HST_SETUP;
        end
      end
      HST_SETUP: begin
        if (tmr == TMR_ZERO) begin
          next_tx_bit = frame[FRAME_BITS-1]; // see R2
          next_tmr = SCLK_HALF_CYC - TMR_ONE;
          next_state = HST_LOW;
        end else begin
          next_tmr = tmr - TMR_ONE;
        end
      end
      HST_LOW: begin
        if (tmr == TMR_ZERO) begin
          next_sclk = 1'b1;
          next_rx = {rx[DATA_BITS-2:0], do_s2};
          next_tmr = SCLK_HALF_CYC - TMR_ONE;
          next_state = HST_HIGH;
        end else begin
          next_tmr = tmr - TMR_ONE;
        end
      end
      HST_HIGH: begin
        if (tmr == TMR_ZERO) begin
          next_sclk = 1'b0;
          if (bitn == FRAME_LAST) begin
            next_tmr = CS_HOLD_CYC - TMR_ONE;
            next_state = HST_HOLD;
          end else begin
            next_bitn = bitn + 5'h01;
            next_frame = {frame[FRAME_BITS-2:0], 1'b0}; // see R7
            next_tx_bit = frame[FRAME_BITS-2]; // see R4
            next_tmr = SCLK_HALF_CYC - TMR_ONE;
            next_state = HST_LOW;
          end
        end else begin
          next_tmr = tmr - TMR_ONE;
        end
      end
      HST_HOLD: begin
        if (tmr == TMR_ZERO) begin
          next_cs_n = 1'b1; // see R1
          next_tx_bit = 1'b0;
          next_done = 1'b1;
          if (rd) begin
            next_rdata = rx; // see R5
          end
          next_tmr = CS_HIGH_CYC - TMR_ONE;
          next_state = HST_GAP;
        end else begin
          next_tmr = tmr - TMR_ONE;
        end
      end
      HST_GAP: begin
        if (tmr == TMR_ZERO) begin
          next_state = HST_IDLE;
        end else begin
          next_tmr = tmr - TMR_ONE;
        end
      end
      default: begin
        next_state = HST_IDLE;
        next_cs_n = 1'b1;
        next_sclk = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      state <= HST_IDLE;
      tmr <= TMR_ZERO;
      bitn <= '0;
      frame <= '0;
      rx <= DATA_ZERO;
      rdata <= DATA_ZERO;
      rd <= 1'b0;
      cs_n <= 1'b1;
      sclk <= 1'b0;
      tx_bit <= 1'b0;
      done <= 1'b0;
    end else begin
      state <= next_state;
      tmr <= next_tmr;
      bitn <= next_bitn;
      frame <= next_frame;
      rx <= next_rx;
      rdata <= next_rdata;
      rd <= next_rd;
      cs_n <= next_cs_n;
      sclk <= next_sclk;
      tx_bit <= next_tx_bit;
      done <= next_done;
    end
  end

  // ==========================================================
  // outputs
  always_comb begin
    link.cs_n = cs_n;
    link.sclk = sclk;
    link.serial_in_line = tx_bit; // see R6
    req_ready_o = (state == HST_IDLE);
    done_o = done;
    rdata_o = rdata;
  end

endmodule
`default_nettype wire

/* design/shrp_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface shrp_if;
  // ==========================================================
  // serial port wires
  logic cs_n;
  logic sclk;
  logic serial_in_line;
  logic out_data;
  logic out_oe;
  wire serial_out_line;

  // released line is pulled high
  assign serial_out_line = out_oe ? out_data : 1'b1;

  modport host (
    output cs_n,
    output sclk,
    output serial_in_line,
    input serial_out_line
  );

  modport dev (
    input cs_n,
    input sclk,
    input serial_in_line,
    output out_data,
    output out_oe
  );
endinterface
`default_nettype wire

/* design/shrp_pkg.sv */
// How it works
// R1 - select falling starts, rising ends a transaction
// R2 - five instruction bits sampled on rising clock
// R3 - instruction MSB one reads, zero writes
// R4 - eleven address bits follow the instruction
// R5 - read data changes on falling clock edges
// R6 - write data follows address, stored in register
// R7 - eight data bits, MSB first, output released
`default_nettype none
package shrp_pkg;

  // ==========================================================
  // frame layout
  localparam int INSTR_BITS = 5;
  localparam int ADDR_BITS = 11;
  localparam int DATA_BITS = 8;
  localparam int FRAME_BITS = INSTR_BITS + ADDR_BITS + DATA_BITS;
  localparam logic [3:0] INSTR_LAST = 4'(INSTR_BITS - 1);
  localparam logic [3:0] ADDR_LAST = 4'(ADDR_BITS - 1);
  localparam logic [3:0] DATA_LAST = 4'(DATA_BITS - 1);
  localparam logic [4:0] FRAME_LAST = 5'(FRAME_BITS - 1);
  localparam logic RD_OP = 1'b1;
  localparam logic WR_OP = 1'b0;
  localparam logic [3:0] INSTR_PAD = 4'h0;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [DATA_BITS-1:0] DATA_ZERO = 8'h00;
  localparam logic [ADDR_BITS-1:0] ADDR_ZERO = 11'h000;

  // ==========================================================
  // timing, in ns and in system clock cycles (rounded up)
  localparam int SYS_CLK_NS = 5;
  localparam int SCLK_HALF_NS = 250;
  localparam int CS_SETUP_NS = 50;
  localparam int CS_HOLD_NS = 100;
  localparam int CS_HIGH_NS = 100;
  localparam logic [7:0] SCLK_HALF_CYC = 8'((SCLK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);
  localparam logic [7:0] CS_SETUP_CYC = 8'((CS_SETUP_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);
  localparam logic [7:0] CS_HOLD_CYC = 8'((CS_HOLD_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);
  localparam logic [7:0] CS_HIGH_CYC = 8'((CS_HIGH_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);
  localparam logic [7:0] TMR_ZERO = 8'h00;
  localparam logic [7:0] TMR_ONE = 8'h01;

  // ==========================================================
  // state types
  typedef enum logic [2:0] {
    DEV_IDLE, DEV_INSTR, DEV_ADDR, DEV_RDATA, DEV_WDATA, DEV_DONE
  } shrp_dev_st_t;

  typedef enum logic [2:0] {
    HST_IDLE, HST_SETUP, HST_LOW, HST_HIGH, HST_HOLD, HST_GAP
  } shrp_hst_st_t;

endpackage
`default_nettype wire

/* test/shrp_chk_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module shrp_chk (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // link wires
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_in_line,
  input wire logic out_data,
  input wire logic out_oe,
  input wire logic serial_out_line
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  // ==========================================================
  // frame steps
  sequence s_cs_rise;
    !cs_n ##1 cs_n;
  endsequence
  sequence s_sclk_rise;
    !sclk ##1 sclk;
  endsequence

  // ==========================================================
  // link checks
  sel_start_a: assert property ($fell(cs_n) |-> !sclk [*8])
    else $error("serial clock not low at select fall");
  sclk_idle_a: assert property (cs_n |-> !sclk)
    else $error("serial clock moved outside a frame");
  cs_high_a: assert property (s_cs_rise |-> cs_n [*8])
    else $error("select high time too short");
  sin_hold_a: assert property (sclk && $past(sclk) |-> $stable(serial_in_line))
    else $error("serial input changed while clock high");
  sclk_high_a: assert property (s_sclk_rise |=> sclk [*8])
    else $error("serial clock high phase too short");
  oe_rise_a: assert property ($rose(out_oe) |-> !sclk && !cs_n)
    else $error("output enabled outside a low clock phase");
  out_shift_a: assert property (out_oe && $changed(out_data) |-> !sclk)
    else $error("output data changed while clock high");
  oe_release_a: assert property (s_cs_rise |-> ##[1:6] !out_oe)
    else $error("output not released after select rise");
  oe_idle_a: assert property (cs_n [*8] |-> !out_oe)
    else $error("output driven while deselected");
  line_pull_a: assert property (!out_oe |-> serial_out_line)
    else $error("released output line not high");
endmodule
`default_nettype wire

/* test/test_serial_host_register_port.sv */
`timescale 1ns/10ps
`default_nettype none
module test_serial_host_register_port
  import shrp_pkg::*;
();
  // ==========================================================
  // signals and instances
  logic sys_clk_i = 1'b0;
  logic nrst_i, req_i, req_rd_i, loc_we_i, req_ready_o, done_o;
  logic wr_stb_o, rd_stb_o, abort_o, busy_o, b_wr, b_abort;
  logic [ADDR_BITS-1:0] req_addr_i, loc_addr_i, reg_addr_o, b_addr;
  logic [DATA_BITS-1:0] req_wdata_i, loc_data_i, rdata_o, reg_data_o, b_data, g;
  logic [23:0] fr_in, fr_out;
  int errors = 0, n_tests = 0, cyc = 0, n_wr = 0, n_ab = 0, n_bwr = 0, n_rd = 0, n_aa = 0;
  shrp_if ifa();
  shrp_if ifb();

  initial begin
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  shrp_host shrp_host_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .link(ifa),
    .req_i(req_i), .req_rd_i(req_rd_i), .req_addr_i(req_addr_i),
    .req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o), .done_o(done_o),
    .rdata_o(rdata_o));
  shrp_dev shrp_dev_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .link(ifa),
    .loc_we_i(loc_we_i), .loc_addr_i(loc_addr_i), .loc_data_i(loc_data_i),
    .wr_stb_o(wr_stb_o), .rd_stb_o(rd_stb_o), .abort_o(abort_o), .busy_o(busy_o),
    .reg_addr_o(reg_addr_o), .reg_data_o(reg_data_o));
  // second device, its link driven by the bench
  shrp_dev shrp_dev_b_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .link(ifb),
    .loc_we_i(1'b0), .loc_addr_i(ADDR_ZERO), .loc_data_i(DATA_ZERO),
    .wr_stb_o(b_wr), .rd_stb_o(), .abort_o(b_abort), .busy_o(),
    .reg_addr_o(b_addr), .reg_data_o(b_data));
  shrp_chk shrp_chk_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .cs_n(ifa.cs_n),
    .sclk(ifa.sclk), .serial_in_line(ifa.serial_in_line), .out_data(ifa.out_data),
    .out_oe(ifa.out_oe), .serial_out_line(ifa.serial_out_line));

  // wire capture, last 24 bits at each clock rise
  always @(posedge ifa.sclk) begin
    fr_in <= {fr_in[22:0], ifa.serial_in_line};
    fr_out <= {fr_out[22:0], ifa.serial_out_line};
  end

  always @(posedge sys_clk_i) begin
    cyc++;
    if (wr_stb_o === 1'b1) n_wr++;
    if (rd_stb_o === 1'b1) n_rd++;
    if (abort_o === 1'b1) n_aa++;
    if (b_wr === 1'b1) n_bwr++;
    if (b_abort === 1'b1) n_ab++;
    if (cyc == 30000) begin
      errors++;
      wrap_up();
    end
  end

  // ==========================================================
  // tasks
  task cmp(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task host_op(input logic rd, input logic [10:0] a, input logic [7:0] d);
    int k;
    k = 0;
    while (req_ready_o !== 1'b1 && k < 100) begin
      @(negedge sys_clk_i);
      k++;
    end
    req_i = 1'b1;
    req_rd_i = rd;
    req_addr_i = a;
    req_wdata_i = d;
    @(negedge sys_clk_i);
    req_i = 1'b0;
    k = 0;
    while (done_o !== 1'b1 && k < 3000) begin
      @(negedge sys_clk_i);
      k++;
    end
    cmp(24'(done_o), 24'h1);
    cmp(24'(req_ready_o), 24'h0);
    cmp(24'(ifa.cs_n), 24'h1);
    cmp(fr_in, {rd, 4'h0, a, rd ? 8'h00 : d});
  endtask

  task link_frame(input logic [23:0] f, input int n, output logic [7:0] got);
    ifb.cs_n = 1'b0;
    #80;
    for (int i = 0; i < n; i++) begin
      ifb.serial_in_line = f[23-i];
      #80 ifb.sclk = 1'b1;
      got = {got[6:0], ifb.serial_out_line};
      #80 ifb.sclk = 1'b0;
    end
    #120 ifb.cs_n = 1'b1;
    ifb.serial_in_line = ~ifb.serial_in_line;
    #400;
  endtask

  task t_reset();
    cmp(24'(ifa.cs_n), 24'h1);
    cmp(24'(ifa.sclk), 24'h0);
    cmp(24'(ifa.serial_out_line), 24'h1);
    cmp(24'(rdata_o), 24'h0);
    cmp(24'(busy_o), 24'h0);
    cmp(24'(req_ready_o), 24'h1);
    $display("test reset done");
  endtask

  task t_wr_rd(input logic [10:0] a, input logic [7:0] d);
    int r;
    host_op(WR_OP, a, d);
    cmp(24'(reg_addr_o), 24'(a));
    cmp(24'(reg_data_o), 24'(d));
    r = n_rd;
    host_op(RD_OP, a, DATA_ZERO);
    cmp(24'(n_rd - r), 24'h1);
    cmp(24'(rdata_o), 24'(d));
    cmp(24'(fr_out[7:0]), 24'(d));
    $display("test write read done");
  endtask

  task t_local();
    int w;
    w = n_wr;
    @(negedge sys_clk_i);
    loc_we_i = 1'b1;
    loc_addr_i = 11'h123;
    loc_data_i = 8'h3C;
    @(negedge sys_clk_i);
    loc_we_i = 1'b0;
    host_op(RD_OP, 11'h123, DATA_ZERO);
    cmp(24'(rdata_o), 24'h3C);
    repeat (8) @(negedge sys_clk_i);
    cmp(24'(busy_o), 24'h0);
    cmp(24'(n_aa), 24'h0);
    cmp(24'(n_wr - w), 24'h0);
    $display("test local read done");
  endtask

  task t_abort();
    link_frame({WR_OP, 4'h0, 11'h055, 8'h96}, 20, g);
    cmp(24'(n_ab), 24'h1);
    cmp(24'(n_bwr), 24'h0);
    link_frame({WR_OP, 4'h0, 11'h055, 8'h96}, 24, g);
    cmp(24'(n_bwr), 24'h1);
    cmp(24'(b_addr), 24'h55);
    cmp(24'(b_data), 24'h96);
    link_frame({RD_OP, 4'h0, 11'h055, 8'h00}, 24, g);
    cmp(24'(g), 24'h96);
    cmp(24'(ifb.serial_out_line), 24'h1);
    $display("test abort done");
  endtask

  task wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    nrst_i = 1'b0;
    req_i = 1'b0;
    req_rd_i = 1'b0;
    req_addr_i = ADDR_ZERO;
    req_wdata_i = DATA_ZERO;
    loc_we_i = 1'b0;
    loc_addr_i = ADDR_ZERO;
    loc_data_i = DATA_ZERO;
    ifb.cs_n = 1'b1;
    ifb.sclk = 1'b0;
    ifb.serial_in_line = 1'b0;
    repeat (16) @(negedge sys_clk_i);
    nrst_i = 1'b1;
    t_reset();
    t_wr_rd(11'h7FF, 8'hA5);
    t_wr_rd(11'h000, 8'h5A);
    t_local();
    t_abort();
    wrap_up();
  end
endmodule
`default_nettype wire
